// ==== logic/vbf_map.svh ====
// constants of the video formatter: state byte offsets, sizes, marker, reset values
// assumes byte addressed state image of 512 bytes forwarded by the sequencing_controller
//
// Contract
// - pixel words count only while line valid and frame valid are both high
// - input path moves one whole sensor word per pixel clock, 100 or 160 bits; here always 100 bits (NPIX*10)
// - fast_muxed_pixel_bus carries half words at twice pixel rate; demultiplex and align
// - vertical binning sums configured rows, emitting one row per group
// - vertical binner output is ten 14-bit pixel sums
// - horizontal binning adds configured adjacent pixels into ten 18-bit sums
// - keep upper or lower 16 bits of each binned pixel by multiplier
// - each FIFO entry holds one pixel block plus its line and frame valid
// - FIFO read and output run at link clock; 33/42.5/66/85 MHz selectable; here both run on clk, stepped by synchronised rising linkClk edges
// - output machine pops entries and spreads pixels by tap count and width
// - no data valid qualifier; every link clock inside line valid carries pixels
// - line valid waits until a whole line is buffered
// - bytes written at random; readback always streams the entire image
// - multi-byte state fields are little endian except reference voltages
// - first four bytes hold a marker showing an initialised buffer
// - readout mode 60, link clock 61, binning 62, memory 63, multiplier 64
// - 384 bytes from byte 128 reserved for formatter extensions
// - state updates change the matching internal configuration at once
// - ROI bounds and periods from byte 36, serial bit period at 58
// - readout mode resets to 0x01, single tap ten bits
`ifndef VBF_MAP_SVH
`define VBF_MAP_SVH
`define VBF_STATE_BYTES   10'h200
`define VBF_OFS_ROI_SPIX  9'h024
`define VBF_OFS_SERIAL    9'h03A
`define VBF_OFS_MODE      9'h03C
`define VBF_OFS_CLKSEL    9'h03D
`define VBF_OFS_BINCTL    9'h03E
`define VBF_OFS_MEMOPT    9'h03F
`define VBF_OFS_BINMUL    9'h040
`define VBF_OFS_EXT_BASE  9'h080
`define VBF_EXT_BYTES     10'h180
`define VBF_MARKER        32'h69F05AC3
`define VBF_MODE_RST      8'h01
`define VBF_ZERO_BYTE     8'h00
`endif

// ==== logic/vbf_pkg.sv ====
// types shared by the video formatter modules
// assumes nothing beyond the map header
`default_nettype none
package vbf_pkg;
  typedef enum logic {VBF_IDLE, VBF_SEND} vbf_out_state_t;
  typedef logic [7:0] vbf_byte_t;
endpackage
`default_nettype wire

// ==== logic/vbf_fifo_if.sv ====
// write and read sides of the pixel block FIFO
// assumes one producer and one consumer on the same clock
`timescale 1ns/1ps
`default_nettype none
interface vbf_fifo_if #(parameter int W = 162) ();
  logic [W-1:0] wData;
  logic         wValid;
  logic         wReady;
  logic [W-1:0] rData;
  logic         rValid;
  logic         rReady;
  modport user (output wData, wValid, rReady, input wReady, rData, rValid);
  modport fifo (input wData, wValid, rReady, output wReady, rData, rValid);
endinterface
`default_nettype wire

// ==== logic/vbf_fifo.sv ====
// pixel block FIFO with Gray coded pointers
// assumes nrst synchronous active low; read data is show-ahead
`timescale 1ns/1ps
`default_nettype none
module vbf_fifo import vbf_pkg::*; #(
  parameter int AW = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // both sides
  vbf_fifo_if.fifo f
);
  logic [f.W-1:0] mem [2**AW];
  logic [AW:0]    wBin_r, rBin_r, wGray_r, rGray_r;
  logic [AW:0]    rGs1_r, rGs2_r, wGs1_r, wGs2_r;
  logic [AW:0]    wBinNxt, rBinNxt;

  function automatic logic [AW:0] toGray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  assign wBinNxt  = wBin_r + {{AW{1'b0}}, 1'b1};
  assign rBinNxt  = rBin_r + {{AW{1'b0}}, 1'b1};
  assign f.wReady = (wGray_r != {~rGs2_r[AW:AW-1], rGs2_r[AW-2:0]});
  assign f.rValid = (rGray_r != wGs2_r);
  assign f.rData  = mem[rBin_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (f.wValid && f.wReady) begin
      mem[wBin_r[AW-1:0]] <= f.wData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wBin_r  <= '0;
      wGray_r <= '0;
      rBin_r  <= '0;
      rGray_r <= '0;
    end else begin
      if (f.wValid && f.wReady) begin
        wBin_r  <= wBinNxt;
        wGray_r <= toGray(wBinNxt);
      end
      if (f.rReady && f.rValid) begin
        rBin_r  <= rBinNxt;
        rGray_r <= toGray(rBinNxt);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rGs1_r <= '0;
      rGs2_r <= '0;
      wGs1_r <= '0;
      wGs2_r <= '0;
    end else begin
      rGs1_r <= rGray_r;
      rGs2_r <= rGs1_r;
      wGs1_r <= wGray_r;
      wGs2_r <= wGs1_r;
    end
  end

  property p_grayStep;
    @(posedge clk) disable iff (!nrst)
      (wGray_r != $past(wGray_r)) |-> $countones(wGray_r ^ $past(wGray_r)) == 1;
  endproperty
  a_grayStep: assert property (p_grayStep) else $error("write gray pointer moved more than one bit");
endmodule
`default_nettype wire

// ==== logic/vbf_formatter.sv ====
// video formatter: demux, vertical and horizontal binning, FIFO, link output
// assumes sensor pins, strobes and link clock are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "vbf_map.svh"
module vbf_formatter import vbf_pkg::*; #(
  parameter int NPIX  = 10,
  parameter int MAXW  = 256,
  parameter int AW    = 6,
  parameter int MAXT  = 10
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // sensor and strobes
  input  wire logic [NPIX*5-3:0]      fastMuxedPixelBus,
  input  wire logic [3:0]             directPixels,
  input  wire logic                   muxPhase,
  input  wire logic                   lineValid,
  input  wire logic                   frameValid,
  // state byte port
  input  wire logic [8:0]             addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wstrobe,
  input  wire logic                   rstrobe,
  output logic      [7:0]             rdata,
  // link
  input  wire logic                   linkClk,
  output logic      [MAXT*16-1:0]     linkPix,
  output logic                        linkLineValid,
  output logic                        linkFrameValid,
  output logic      [1:0]             linkClkSel,
  // status
  output logic                        stateValid,
  output logic                        overflow,
  output logic      [15:0]            roiStartPix
);
  localparam int HW = NPIX * 5 - 2;
  localparam int FW = NPIX * 16 + 2;

  // state memory
  logic [7:0] stateMem [`VBF_STATE_BYTES];
  logic [8:0] readPtr_r;
  logic [7:0] readoutMode_r, binCtl_r, binMult_r, memOpt_r;
  logic [7:0] mark_r [4];

  always_ff @(posedge clk) begin
    if (wstrobe) begin
      stateMem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      readPtr_r <= '0;
      rdata     <= `VBF_ZERO_BYTE;
    end else if (rstrobe) begin
      rdata     <= stateMem[readPtr_r];
      readPtr_r <= readPtr_r + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      readoutMode_r <= `VBF_MODE_RST;
      linkClkSel    <= 2'h0;
      binCtl_r      <= `VBF_ZERO_BYTE;
      memOpt_r      <= `VBF_ZERO_BYTE;
      binMult_r     <= `VBF_ZERO_BYTE;
    end else if (wstrobe) begin
      if (addr == `VBF_OFS_MODE) begin
        readoutMode_r <= wdata;
      end else if (addr == `VBF_OFS_CLKSEL) begin
        linkClkSel <= wdata[1:0];
      end else if (addr == `VBF_OFS_BINCTL) begin
        binCtl_r <= wdata;
      end else if (addr == `VBF_OFS_MEMOPT) begin
        memOpt_r <= wdata;
      end else if (addr == `VBF_OFS_BINMUL) begin
        binMult_r <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      roiStartPix <= 16'h0000;
    end else if (wstrobe && addr == `VBF_OFS_ROI_SPIX) begin
      roiStartPix[7:0] <= wdata;
    end else if (wstrobe && addr == `VBF_OFS_ROI_SPIX + 9'h001) begin
      roiStartPix[15:8] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        mark_r[i] <= `VBF_ZERO_BYTE;
      end
      stateValid <= 1'b0;
    end else begin
      if (wstrobe && addr[8:2] == 7'h00) begin
        mark_r[addr[1:0]] <= wdata;
      end
      stateValid <= ({mark_r[3], mark_r[2], mark_r[1], mark_r[0]} == `VBF_MARKER);
    end
  end

  // input synchronisers
  logic [HW+7:0] pinS1_r, pinS2_r;
  logic [HW-1:0] halfLo_r;
  logic          lvS, fvS, phS, lvPrev_r, phPrev_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pinS1_r <= '0;
      pinS2_r <= '0;
    end else begin
      pinS1_r <= {linkClk, lineValid, frameValid, muxPhase, directPixels, fastMuxedPixelBus};
      pinS2_r <= pinS1_r;
    end
  end
  assign phS = pinS2_r[HW+4];
  assign fvS = pinS2_r[HW+5];
  assign lvS = pinS2_r[HW+6];

  // demultiplex two halves into one word
  logic [NPIX*10-1:0] word_r;
  logic               wordValid_r, lineEnd_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      halfLo_r    <= '0;
      word_r      <= '0;
      wordValid_r <= 1'b0;
      lineEnd_r   <= 1'b0;
      lvPrev_r    <= 1'b0;
      phPrev_r    <= 1'b0;
    end else begin
      lvPrev_r  <= lvS;
      phPrev_r  <= phS;
      lineEnd_r <= lvPrev_r && !lvS;
      if (phS) begin
        halfLo_r <= pinS2_r[HW-1:0];
      end
      // one word per pixel clock while strobes high
      wordValid_r <= phPrev_r && !phS && lvS && fvS;
      if (phPrev_r && !phS) begin
        word_r <= {pinS2_r[HW+3:HW], pinS2_r[HW-1:0], halfLo_r};
      end
    end
  end

  // vertical binning
  logic [NPIX*14-1:0] rowMem [MAXW];
  logic [NPIX*14-1:0] vSum, vWord_r;
  logic [$clog2(MAXW)-1:0] col_r;
  logic [3:0]         rowCnt_r, vFac, hFac, hCnt_r;
  logic               vValid_r, vEnd_r, hEnd_r;
  assign vFac = binCtl_r[3:0];
  assign hFac = binCtl_r[7:4];

  generate
    for (genvar g = 0; g < NPIX; g++) begin : gV
      assign vSum[g*14 +: 14] = (rowCnt_r == 4'h0) ? {4'h0, word_r[g*10 +: 10]}
                              : rowMem[col_r][g*14 +: 14] + {4'h0, word_r[g*10 +: 10]};
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (wordValid_r) begin
      rowMem[col_r] <= vSum;
    end
  end

  // emit one row per binning group
  always_ff @(posedge clk) begin
    if (!nrst) begin
      col_r    <= '0;
      rowCnt_r <= 4'h0;
      vWord_r  <= '0;
      vValid_r <= 1'b0;
      vEnd_r   <= 1'b0;
    end else begin
      vValid_r <= wordValid_r && rowCnt_r == vFac;
      vEnd_r   <= lineEnd_r && rowCnt_r == vFac;
      if (wordValid_r) begin
        vWord_r <= vSum;
        col_r   <= col_r + 1'b1;
      end
      if (!fvS) begin
        rowCnt_r <= 4'h0;
        col_r    <= '0;
      end else if (lineEnd_r) begin
        col_r    <= '0;
        rowCnt_r <= (rowCnt_r == vFac) ? 4'h0 : rowCnt_r + 4'h1;
      end
    end
  end

  // horizontal binning
  logic [NPIX*18-1:0] hAcc_r, hSum;
  logic               hValid_r;
  generate
    for (genvar g = 0; g < NPIX; g++) begin : gH
      assign hSum[g*18 +: 18] = (hCnt_r == 4'h0) ? {4'h0, vWord_r[g*14 +: 14]}
                              : hAcc_r[g*18 +: 18] + {4'h0, vWord_r[g*14 +: 14]};
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hAcc_r   <= '0;
      hCnt_r   <= 4'h0;
      hValid_r <= 1'b0;
      hEnd_r   <= 1'b0;
    end else begin
      hValid_r <= vValid_r && hCnt_r == hFac;
      hEnd_r   <= vEnd_r;
      if (vEnd_r) begin
        hCnt_r <= 4'h0;
      end else if (vValid_r) begin
        hAcc_r <= hSum;
        hCnt_r <= (hCnt_r == hFac) ? 4'h0 : hCnt_r + 4'h1;
      end
    end
  end

  // pixel block FIFO
  vbf_fifo_if #(.W(FW)) fq ();
  vbf_fifo #(.AW(AW)) uFifo (.clk(clk), .nrst(nrst), .f(fq));

  logic [NPIX*16-1:0] selPix;
  // keep upper or lower 16 bits
  generate
    for (genvar g = 0; g < NPIX; g++) begin : gS
      assign selPix[g*16 +: 16] = binMult_r[0] ? hAcc_r[g*18+2 +: 16] : hAcc_r[g*18 +: 16];
    end
  endgenerate
  // entry holds block with line and frame valid
  assign fq.wValid = hValid_r || hEnd_r;
  assign fq.wData  = hEnd_r ? {1'b0, fvS, {NPIX*16{1'b0}}} : {1'b1, 1'b1, selPix};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      overflow <= 1'b0;
    end else if (fq.wValid && !fq.wReady) begin
      overflow <= 1'b1;
    end
  end

  // link output
  function automatic logic [3:0] tapsOf(input logic [7:0] m);
    if (m <= 8'h03) return 4'h1;
    else if (m <= 8'h06) return 4'h2;
    else if (m >= 8'h0A && m <= 8'h0D) return 4'h4;
    else if (m == 8'h12 || m == 8'h13) return 4'h8;
    else if (m == 8'h14) return 4'hA;
    else return 4'h0;
  endfunction

  function automatic logic [15:0] maskOf(input logic [7:0] m);
    if (m == 8'h01 || m == 8'h05 || m == 8'h0B || m == 8'h13) return 16'h03FF;
    else if (m == 8'h02 || m == 8'h06 || m == 8'h0C) return 16'h0FFF;
    else if (m == 8'h03 || m == 8'h0D) return 16'hFFFF;
    else return 16'h00FF;
  endfunction

  logic          lkS3_r, linkRise;
  logic [4:0]    off_r, offNxt;
  logic [AW:0]   linesReady_r;
  logic [3:0]    taps;
  logic          popMark, pushMark;
  vbf_out_state_t outState_r;

  assign taps     = tapsOf(readoutMode_r);
  assign offNxt   = off_r + {1'b0, taps};
  assign linkRise = pinS2_r[HW+7] && !lkS3_r;
  assign pushMark = hEnd_r && fq.wReady;
  assign popMark  = fq.rReady && fq.rValid && !fq.rData[FW-1];
  // pop a block once its pixels are sent
  assign fq.rReady = linkRise && fq.rValid && linesReady_r != '0 &&
                     (!fq.rData[FW-1] || taps == 4'h0 || offNxt >= 5'(NPIX));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lkS3_r       <= 1'b0;
      linesReady_r <= '0;
    end else begin
      lkS3_r <= pinS2_r[HW+7];
      linesReady_r <= linesReady_r + (pushMark ? 1'b1 : 1'b0) - (popMark ? 1'b1 : 1'b0);
    end
  end

  // one pixel group on every rising link edge of a line
  always_ff @(posedge clk) begin
    if (!nrst) begin
      outState_r     <= VBF_IDLE;
      off_r          <= 5'h00;
      linkPix        <= '0;
      linkLineValid  <= 1'b0;
      linkFrameValid <= 1'b0;
    end else if (linkRise && fq.rValid && linesReady_r != '0 && taps != 4'h0) begin
      case (outState_r)
        VBF_IDLE: begin
          if (!fq.rData[FW-1]) begin
            linkFrameValid <= fq.rData[FW-2];
          end else begin
            outState_r     <= VBF_SEND;
            linkLineValid  <= 1'b1;
            linkFrameValid <= 1'b1;
          end
        end
        VBF_SEND: begin
          if (!fq.rData[FW-1]) begin
            outState_r     <= VBF_IDLE;
            linkLineValid  <= 1'b0;
            linkFrameValid <= fq.rData[FW-2];
          end
        end
        default: outState_r <= VBF_IDLE;
      endcase
      if (fq.rData[FW-1]) begin
        for (int t = 0; t < MAXT; t++) begin
          linkPix[t*16 +: 16] <= (t < int'(taps) && int'(off_r) + t < NPIX) ?
                                 fq.rData[(int'(off_r) + t)*16 +: 16] & maskOf(readoutMode_r) : 16'h0000;
        end
        off_r <= (offNxt >= 5'(NPIX)) ? 5'h00 : offNxt;
      end else begin
        off_r <= 5'h00;
      end
    end else if (linkRise && !linkLineValid) begin
      linkPix <= '0;
    end
  end

  // assertions
  property p_validWord;
    @(posedge clk) disable iff (!nrst) wordValid_r |-> $past(lvS) && $past(fvS);
  endproperty
  a_validWord: assert property (p_validWord) else $error("word taken outside line and frame valid");

  property p_wordRate;
    @(posedge clk) disable iff (!nrst) wordValid_r |=> !wordValid_r;
  endproperty
  a_wordRate: assert property (p_wordRate) else $error("more than one word per pixel clock");

  property p_demux;
    @(posedge clk) disable iff (!nrst)
      wordValid_r |-> word_r[NPIX*10-1 -: 4] == $past(pinS2_r[HW+3:HW]) && word_r[HW-1:0] == $past(halfLo_r);
  endproperty
  a_demux: assert property (p_demux) else $error("demultiplexed word misaligned");

  property p_vGroup;
    @(posedge clk) disable iff (!nrst) vValid_r |-> $past(rowCnt_r == vFac);
  endproperty
  a_vGroup: assert property (p_vGroup) else $error("vertical row emitted before group complete");

  property p_hGroup;
    @(posedge clk) disable iff (!nrst) hValid_r |-> $past(hCnt_r == hFac) && $past(vValid_r);
  endproperty
  a_hGroup: assert property (p_hGroup) else $error("horizontal sum emitted early");

  property p_modeWrite;
    @(posedge clk) disable iff (!nrst)
      wstrobe && addr == `VBF_OFS_MODE |=> readoutMode_r == $past(wdata);
  endproperty
  a_modeWrite: assert property (p_modeWrite) else $error("readout mode not updated by state write");

  property p_modeReset;
    @(posedge clk) $rose(nrst) |-> readoutMode_r == `VBF_MODE_RST;
  endproperty
  a_modeReset: assert property (p_modeReset) else $error("readout mode reset value wrong");

  property p_readStream;
    @(posedge clk) disable iff (!nrst) rstrobe |=> readPtr_r == $past(readPtr_r) + 9'h001;
  endproperty
  a_readStream: assert property (p_readStream) else $error("readback pointer did not advance");

  property p_lineStart;
    @(posedge clk) disable iff (!nrst) $rose(linkLineValid) |-> $past(linesReady_r != '0);
  endproperty
  a_lineStart: assert property (p_lineStart) else $error("line valid raised without a buffered line");

  property p_noGap;
    @(posedge clk) disable iff (!nrst) linkLineValid && linkRise |-> fq.rValid;
  endproperty
  a_noGap: assert property (p_noGap) else $error("FIFO empty inside a line");

  c_line:   cover property (@(posedge clk) disable iff (!nrst) $fell(linkLineValid));
  c_vbin:   cover property (@(posedge clk) disable iff (!nrst) vValid_r && vFac != 4'h0);
  c_upper:  cover property (@(posedge clk) disable iff (!nrst) fq.wValid && binMult_r[0]);
endmodule
`default_nettype wire

// ==== testbench/vbf_grabber.sv ====
// frame grabber model: makes the link clock and measures every received line
// assumes formatter outputs settle well inside one link clock period
`timescale 1ns/1ps
`default_nettype none
module vbf_grabber (
  // control
  input  wire logic        run,
  // link
  output logic             linkClk,
  input  wire logic        linkLineValid,
  input  wire logic        linkFrameValid,
  // line statistics
  output logic [15:0]      lineCount,
  output logic [15:0]      lineLen,
  output logic             fvLost
);
  logic [15:0] runLen;
  logic        lvLast;
  initial begin
    linkClk = 1'b0;
    #7;
    forever begin
      #100;
      if (run || linkClk)
        linkClk = ~linkClk;
    end
  end
  initial begin
    lineCount = 16'h0000;
    lineLen = 16'h0000;
    fvLost = 1'b0;
    runLen = 16'h0000;
    lvLast = 1'b0;
  end
  // a gap splits a line and shows as a short length
  always @(posedge linkClk) begin
    if (linkLineValid && !linkFrameValid)
      fvLost <= 1'b1;
    runLen <= linkLineValid ? runLen + 16'h0001 : 16'h0000;
    if (lvLast && !linkLineValid) begin
      lineCount <= lineCount + 16'h0001;
      lineLen <= runLen;
    end
    lvLast <= linkLineValid;
  end
endmodule
`default_nettype wire

// ==== testbench/video_binning_link_formatter_bench.sv ====
// self-checking bench of the video formatter: state bytes, sensor words, link lines
// assumes the grabber model makes the link clock and counts lines
`timescale 1ns/1ps
`default_nettype none
`include "vbf_map.svh"
module video_binning_link_formatter_bench;
  localparam logic [7:0] MC [8] = '{8'h01, 8'h03, 8'h05, 8'h0B, 8'h12, 8'h14, 8'h0C, 8'h02};
  localparam int         MT [8] = '{1, 1, 2, 4, 8, 10, 4, 1};
  localparam int         MW [8] = '{10, 16, 10, 10, 8, 8, 12, 12};
  logic         clk, nrst, muxPhase, lineValid, frameValid, wstrobe, rstrobe, run, rdLag;
  logic [47:0]  fastMuxedPixelBus;
  logic [3:0]   directPixels;
  logic [8:0]   addr;
  logic [7:0]   wdata, rdata;
  logic [159:0] linkPix;
  logic         linkClk, linkLineValid, linkFrameValid, stateValid, overflow, fvLost;
  logic [1:0]   linkClkSel;
  logic [15:0]  roiStartPix, lineCount, lineLen, expLines, expLen, mMask;
  logic [8:0]   shd [512];
  logic [9:0]   px [4][4][10];
  logic [8:0]   rdQ [$];
  logic [159:0] pixQ [$];
  int           bad_count, total_checks, mTaps;

  vbf_formatter DUT (.clk(clk), .nrst(nrst), .fastMuxedPixelBus(fastMuxedPixelBus),
    .directPixels(directPixels), .muxPhase(muxPhase), .lineValid(lineValid),
    .frameValid(frameValid), .addr(addr), .wdata(wdata), .wstrobe(wstrobe),
    .rstrobe(rstrobe), .rdata(rdata), .linkClk(linkClk), .linkPix(linkPix),
    .linkLineValid(linkLineValid), .linkFrameValid(linkFrameValid),
    .linkClkSel(linkClkSel), .stateValid(stateValid), .overflow(overflow),
    .roiStartPix(roiStartPix));
  vbf_grabber grabber (.run(run), .linkClk(linkClk), .linkLineValid(linkLineValid),
    .linkFrameValid(linkFrameValid), .lineCount(lineCount), .lineLen(lineLen),
    .fvLost(fvLost));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstrobe <= 1'b1;
    shd[a] = {1'b0, d};
    @(posedge clk);
    wstrobe <= 1'b0;
  endtask

  task automatic rdAll(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rstrobe <= 1'b1;
      addr <= 9'($urandom);
      rdQ.push_back(shd[i % 512]);
    end
    @(posedge clk);
    rstrobe <= 1'b0;
  endtask

  task automatic mode(input logic [7:0] m, input int taps, input int wid);
    wr(`VBF_OFS_MODE, m);
    mTaps = taps;
    mMask = 16'((17'h1 << wid) - 1);
  endtask

  // low half then high half, each held three clocks
  task automatic word(input logic [99:0] w, input logic lv, input logic fv);
    @(posedge clk);
    fastMuxedPixelBus <= w[47:0];
    muxPhase <= 1'b1;
    lineValid <= lv;
    frameValid <= fv;
    repeat (3) @(posedge clk);
    fastMuxedPixelBus <= w[95:48];
    directPixels <= w[99:96];
    muxPhase <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic frame(input int nl, input int nw, input int vb, input int hb, input logic mul);
    logic [99:0]  w;
    logic [17:0]  s;
    logic [15:0]  v [10];
    logic [159:0] g;
    for (int r = 0; r < nl; r++)
      for (int c = 0; c < nw; c++)
        for (int k = 0; k < 10; k++)
          px[r][c][k] = 10'($urandom);
    // sums, kept half, then groups of taps
    for (int r = 0; r < nl / vb; r++) begin
      for (int c = 0; c < nw / hb; c++) begin
        for (int k = 0; k < 10; k++) begin
          s = '0;
          for (int i = 0; i < vb * hb; i++)
            s = s + 18'(px[r * vb + i / hb][c * hb + i % hb][k]);
          v[k] = (mul ? s[17:2] : s[15:0]) & mMask;
        end
        for (int o = 0; o < 10; o += mTaps) begin
          g = '0;
          for (int t = 0; t < mTaps && o + t < 10; t++)
            g[(t * 16) +: 16] = v[o + t];
          pixQ.push_back(g);
        end
      end
    end
    expLines = expLines + 16'(nl / vb);
    expLen = 16'((nw / hb) * ((10 + mTaps - 1) / mTaps));
    run <= 1'b1;
    // words without both strobes must be dropped
    word('1, 1'b1, 1'b0);
    for (int r = 0; r < nl; r++) begin
      for (int c = 0; c < nw; c++) begin
        for (int k = 0; k < 10; k++)
          w[k * 10 +: 10] = px[r][c][k];
        word(w, 1'b1, 1'b1);
      end
      word(~w, 1'b0, 1'b1);
    end
    word('0, 1'b0, 1'b0);
    for (int i = 0; i < 40000 && (pixQ.size() > 0 || linkLineValid !== 1'b0); i++)
      @(posedge clk);
    repeat (40) @(posedge clk);
    run <= 1'b0;
    check(pixQ.size(), 0);
    check(lineCount, expLines);
    check(lineLen, expLen);
    check(fvLost, 1'b0);
    $display("test frame of %0d lines done", nl);
  endtask

  always @(posedge clk) begin
    if (rdLag === 1'b1) begin
      if (!rdQ[0][8])
        check(rdata, rdQ[0][7:0]);
      void'(rdQ.pop_front());
    end
    rdLag <= rstrobe;
  end

  always @(posedge linkClk) begin
    if (linkLineValid === 1'b1) begin
      if (pixQ.size() == 0)
        check(1'b1, 1'b0);
      else
        check(linkPix, pixQ.pop_front());
    end
  end

  initial begin
    #1000000;
    bad_count++;
    test_done();
  end

  initial begin
    {nrst, muxPhase, lineValid, frameValid, wstrobe, rstrobe, run, rdLag} = '0;
    {fastMuxedPixelBus, directPixels, addr, wdata} = '0;
    void'($urandom(43));
    for (int i = 0; i < 512; i++)
      shd[i] = 9'h100;
    expLines = '0;
    mTaps = 1;
    mMask = 16'h03FF;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check({linkClkSel, stateValid, overflow, linkLineValid, roiStartPix}, '0);
    for (int i = 0; i < 4; i++)
      wr(9'(i), 8'(`VBF_MARKER >> (8 * i)));
    repeat (3) @(posedge clk);
    check(stateValid, 1'b1);
    wr(9'h002, 8'h00);
    repeat (3) @(posedge clk);
    check(stateValid, 1'b0);
    wr(9'h002, 8'hF0);
    wr(`VBF_OFS_ROI_SPIX, 8'($urandom));
    wr(`VBF_OFS_ROI_SPIX + 9'h001, 8'($urandom));
    wr(`VBF_OFS_CLKSEL, 8'($urandom));
    wr(`VBF_OFS_MEMOPT, 8'($urandom));
    wr(`VBF_OFS_EXT_BASE + 9'($urandom % 384), 8'($urandom));
    repeat (2) @(posedge clk);
    check(roiStartPix, {shd[`VBF_OFS_ROI_SPIX + 1][7:0], shd[`VBF_OFS_ROI_SPIX][7:0]});
    check(linkClkSel, shd[`VBF_OFS_CLKSEL][1:0]);
    rdAll(516);
    repeat (3) @(posedge clk);
    check(stateValid, 1'b1);
    $display("test state bytes done");
    frame(2, 3, 1, 1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      mode(MC[i], MT[i], MW[i]);
      wr(`VBF_OFS_BINMUL, 8'(i % 2));
      frame(1 + $urandom % 3, 1 + $urandom % 4, 1, 1, 1'(i % 2));
    end
    wr(`VBF_OFS_BINCTL, 8'h11);
    wr(`VBF_OFS_BINMUL, 8'h01);
    mode(8'h13, 8, 10);
    frame(4, 4, 2, 2, 1'b1);
    check(overflow, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
